// *** rtl/mrb_pkg.sv ***
// Constants, types and CRC step for the read response builder
package mrb_pkg;
    // --------------------------------------------------------------
    // Function and exception codes, count field limits
    // --------------------------------------------------------------
    localparam logic [7:0]  FN_DISC     = 8'h02;
    localparam logic [7:0]  FN_HOLD     = 8'h03;
    localparam logic [7:0]  FN_INPUT    = 8'h04;
    localparam logic [7:0]  EXC_FLAG    = 8'h80;
    localparam logic [7:0]  EXC_ADDR    = 8'h02;
    localparam logic [7:0]  EXC_DATA    = 8'h03;
    localparam logic [7:0]  EXC_DEV     = 8'h04;
    localparam logic [7:0]  EXC_BUSY    = 8'h05;
    localparam logic [7:0]  CNT_HI      = 8'h00;
    localparam logic [7:0]  MAX_FLOAT   = 8'h08;
    // --------------------------------------------------------------
    // Frame layout and CRC
    // --------------------------------------------------------------
    localparam logic [2:0]  QRY_LAST    = 3'h7;
    localparam logic [1:0]  HDR_LAST    = 2'h2;
    localparam logic [1:0]  WORD_LAST   = 2'h1;
    localparam logic [1:0]  FLOAT_LAST  = 2'h3;
    localparam logic [2:0]  BIT_LAST    = 3'h7;
    localparam logic [15:0] CRC_INIT    = 16'hffff;
    localparam logic [15:0] CRC_POLY    = 16'ha001;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;

    typedef enum logic [1:0] {
        KIND_BIT   = 2'b00,
        KIND_WORD  = 2'b01,
        KIND_FLOAT = 2'b10
    } mrb_kind_type;

    typedef struct packed {
        logic         valid;
        mrb_kind_type kind;
        logic [15:0]  addr;
    } mrb_mem_req_type;

    typedef struct packed {
        logic        mapped;
        logic        read_lvl1;
        logic        fresh;
        logic [31:0] value;
    } mrb_mem_rsp_type;

    function automatic logic [15:0] mrb_crc_step(input logic [15:0] crc_in,
                                                 input logic [7:0]  data);
        logic [15:0] c;
        c = crc_in ^ {8'h00, data};
        for (int b = 0; b < 8; b++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : mrb_crc_step
endpackage : mrb_pkg

// *** rtl/mrb_read_builder.sv ***
// Query decoder and reply builder for discrete, word and float reads
//
// Operation
// - Function 02 query: address, 02, start hi/lo, 00, N, CRC lo/hi.
// - Discrete input served only if mapped to a level-1 readable bit.
// - First requested input in bit 0 of first byte, next upward.
// - Unused high bits of last discrete byte are zero.
// - Discrete byte count is N divided by eight, rounded up.
// - Reply: address, code, byte count, data, CRC low then high.
// - Codes 03/04 need level-1 word mapping; addresses step by one.
// - Word query: 03 or 04, start hi/lo, 00, N, CRC lo/hi.
// - Word reply count 2N, each value high byte first.
// - Float variant needs level-1 float mapping; addresses step by two.
// - Float query count field holds twice the float count, high byte 00.
// - Float reply count 4N, four bytes per value, then CRC.
// - Float byte order set by reverse and pairwise exchange bits.
// - Over eight floats or odd register count gives exception 03.
// - Any unconfigured address gives exception 02.
// - Stale field data gives 04; repeat before update gives 05.
`timescale 1ns/1ps
module mrb_read_builder
    import mrb_pkg::*;
(
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    // Received bytes, same clock
    input  wire logic                     rx_valid,
    input  wire logic [7:0]               rx_data,
    input  wire logic                     rx_gap,
    // Configuration
    input  wire logic [7:0]               slave_addr,
    input  wire logic                     float_mode,
    input  wire logic                     byte_reverse,
    input  wire logic                     pair_swap,
    // Memory image
    output mrb_pkg::mrb_mem_req_type      mem_req,
    input  wire mrb_pkg::mrb_mem_rsp_type mem_rsp,
    input  wire logic                     image_update,
    output logic                          refresh_req,
    // Reply bytes
    output logic                          tx_valid,
    output logic [7:0]                    tx_data,
    input  wire logic                     tx_ready
);
    import mrb_pkg::*;

    typedef enum logic [3:0] {
        S_RX      = 4'b0000,
        S_DECODE  = 4'b0001,
        S_CHK_REQ = 4'b0010,
        S_CHK_RSP = 4'b0011,
        S_HDR     = 4'b0100,
        S_FETCH   = 4'b0101,
        S_FWAIT   = 4'b0110,
        S_EMIT    = 4'b0111,
        S_CRC     = 4'b1000
    } mrb_state_type;

    mrb_state_type state;
    logic [7:0]    q [0:7];
    logic [2:0]    rx_cnt;
    logic [15:0]   crc;
    logic          exc;
    logic [7:0]    exc_code;
    logic [8:0]    idx;
    logic [1:0]    hdr_idx;
    logic [1:0]    byte_k;
    logic          crc_k;
    logic [31:0]   hold;
    logic [7:0]    disc_bits;
    logic          bad_map;
    logic          bad_fresh;
    logic          fetched_last;
    logic [31:0]   last_sig;
    logic          sig_valid;
    logic          upd_seen;

    // --------------------------------------------------------------
    // Query field decode
    // --------------------------------------------------------------
    wire [7:0]  fn        = q[1];
    wire [15:0] start     = {q[2], q[3]};
    wire [7:0]  cnt       = q[5];
    wire        is_disc   = (fn == FN_DISC);
    wire        is_float  = (fn == FN_HOLD) && float_mode;
    wire        fn_ok     = is_disc || (fn == FN_HOLD) || (fn == FN_INPUT);
    wire [7:0]  n_items   = is_float ? {1'b0, cnt[7:1]} : cnt;
    // Float count must be even and at most eight values
    wire        fmt_bad   = (q[4] != CNT_HI) || (cnt == CNT_HI) ||
                            (is_float && (cnt[0] || n_items > MAX_FLOAT));
    wire        accept    = (q[0] == slave_addr) && (crc == CRC_RESIDUE) && fn_ok;
    wire [31:0] cur_sig   = {fn, start, cnt};
    wire        repeat_q  = sig_valid && (last_sig == cur_sig) && !upd_seen;
    wire        last_item = (idx == {1'b0, n_items} - 9'h001);
    wire        item_bad  = !(mem_rsp.mapped && mem_rsp.read_lvl1);
    wire        map_fail  = bad_map || item_bad;
    wire        stale     = bad_fresh || !mem_rsp.fresh;
    wire mrb_kind_type kind = mrb_kind_type'(is_disc ? KIND_BIT
                                            : (is_float ? KIND_FLOAT : KIND_WORD));
    wire [15:0] item_addr = start + (is_float ? {6'h00, idx, 1'b0}
                                              : {7'h00, idx});

    // --------------------------------------------------------------
    // Reply byte selection
    // --------------------------------------------------------------
    wire [9:0]  disc_cnt  = ({2'b00, n_items} + 10'h007) >> 3;
    wire [9:0]  wide_cnt  = is_float ? {n_items, 2'b00}
                                     : {1'b0, n_items, 1'b0};
    wire [7:0]  byte_cnt  = is_disc ? disc_cnt[7:0] : wide_cnt[7:0];
    wire [1:0]  f_sel     = (byte_k ^ {1'b0, pair_swap}) ^ {2{byte_reverse}};
    wire [7:0]  f_byte    = hold[{f_sel, 3'b000} +: 8];
    wire [7:0]  w_byte    = (byte_k == 2'b00) ? hold[15:8] : hold[7:0];
    wire [7:0]  e_byte    = is_disc ? disc_bits : (is_float ? f_byte : w_byte);
    wire [1:0]  e_last    = is_disc ? 2'b00 : (is_float ? FLOAT_LAST : WORD_LAST);
    wire [7:0]  h_byte    = (hdr_idx == 2'b00) ? slave_addr :
                            (hdr_idx == 2'b01) ? (exc ? (fn | EXC_FLAG) : fn) :
                            (exc ? exc_code : byte_cnt);
    wire [7:0]  c_byte    = crc_k ? crc[15:8] : crc[7:0];
    wire        sending   = (state == S_HDR) || (state == S_EMIT) || (state == S_CRC);
    wire        load      = sending && (!tx_valid || tx_ready);
    wire [7:0]  out_byte  = (state == S_HDR) ? h_byte :
                            (state == S_EMIT) ? e_byte : c_byte;
    wire        sig_store = (state == S_CRC) && load && crc_k && !exc;
    wire [15:0] crc_base  = (rx_cnt == 3'h0) ? CRC_INIT : crc;
    wire        next_upd  = image_update || (upd_seen && !sig_store);

    // --------------------------------------------------------------
    // Query capture
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_cnt <= 3'h0;
            for (int i = 0; i < 8; i++) q[i] <= 8'h00;
        end else if (state == S_RX) begin
            if (rx_gap) begin
                rx_cnt <= 3'h0;
            end else if (rx_valid) begin
                q[rx_cnt] <= rx_data;
                rx_cnt    <= rx_cnt + 3'h1;
            end
        end
    end

    // --------------------------------------------------------------
    // Repeat tracking
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_sig  <= 32'h0000_0000;
            sig_valid <= 1'b0;
            upd_seen  <= 1'b0;
        end else begin
            upd_seen <= next_upd;
            if (sig_store) begin
                last_sig  <= cur_sig;
                sig_valid <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // Output byte register
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
        end else if (load) begin
            tx_valid <= 1'b1;
            tx_data  <= out_byte;
        end else if (tx_ready) begin
            tx_valid <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_RX; crc <= CRC_INIT; exc <= 1'b0; exc_code <= 8'h00;
            idx <= 9'h000; hdr_idx <= 2'b00; byte_k <= 2'b00; crc_k <= 1'b0;
            hold <= 32'h0000_0000; disc_bits <= 8'h00; bad_map <= 1'b0;
            bad_fresh <= 1'b0; fetched_last <= 1'b0; refresh_req <= 1'b0;
            mem_req <= '0;
        end else begin
            refresh_req   <= 1'b0;
            mem_req.valid <= 1'b0;
            case (state)
                S_RX: begin
                    if (!rx_gap && rx_valid) begin
                        crc <= mrb_crc_step(crc_base, rx_data);
                        if (rx_cnt == QRY_LAST) state <= S_DECODE;
                    end
                end
                S_DECODE: begin
                    idx <= 9'h000; bad_map <= 1'b0; bad_fresh <= 1'b0;
                    exc <= fmt_bad; exc_code <= EXC_DATA; hdr_idx <= 2'b00;
                    crc <= CRC_INIT;
                    refresh_req <= accept;
                    // Frames for other stations or codes pass silently
                    if (!accept) state <= S_RX;
                    else if (fmt_bad) state <= S_HDR;
                    else state <= S_CHK_REQ;
                end
                S_CHK_REQ, S_FETCH: begin
                    mem_req <= '{valid: 1'b1, kind: kind, addr: item_addr};
                    state   <= (state == S_FETCH) ? S_FWAIT : S_CHK_RSP;
                end
                S_CHK_RSP: begin
                    bad_map   <= map_fail;
                    bad_fresh <= stale;
                    idx       <= idx + 9'h001;
                    state     <= last_item ? S_HDR : S_CHK_REQ;
                    if (last_item) begin
                        exc      <= map_fail || stale || repeat_q;
                        exc_code <= map_fail ? EXC_ADDR : (stale ? EXC_DEV : EXC_BUSY);
                    end
                end
                S_HDR: if (load) begin
                    crc     <= mrb_crc_step(crc, out_byte);
                    hdr_idx <= hdr_idx + 2'b01;
                    idx <= 9'h000; disc_bits <= 8'h00; crc_k <= 1'b0;
                    if (hdr_idx == HDR_LAST) state <= exc ? S_CRC : S_FETCH;
                end
                S_FWAIT: begin
                    hold         <= mem_rsp.value;
                    idx          <= idx + 9'h001;
                    fetched_last <= last_item;
                    byte_k       <= 2'b00;
                    if (is_disc) disc_bits[idx[2:0]] <= mem_rsp.value[0];
                    state <= (!is_disc || last_item || idx[2:0] == BIT_LAST) ? S_EMIT
                                                                             : S_FETCH;
                end
                S_EMIT: if (load) begin
                    crc    <= mrb_crc_step(crc, out_byte);
                    byte_k <= byte_k + 2'b01;
                    if (byte_k == e_last) begin
                        disc_bits <= 8'h00;
                        state     <= fetched_last ? S_CRC : S_FETCH;
                    end
                end
                S_CRC: if (load) begin
                    crc_k <= 1'b1;
                    if (crc_k) state <= S_RX;
                end
                default: state <= S_RX;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence hdr_third;
        state == S_HDR && load && hdr_idx == HDR_LAST && !exc;
    endsequence

    chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte changed while stalled");
    chk_hdr_echo: assert property (state == S_HDR && load && hdr_idx == 2'b00
        |=> tx_data == slave_addr)
        else $error("reply does not start with station address");
    chk_disc_count: assert property (hdr_third and is_disc
        |=> {tx_data, 3'b000} >= {3'b000, cnt} && {tx_data, 3'b000} < {3'b000, cnt} + 11'h008)
        else $error("discrete byte count wrong");
    chk_word_count: assert property (hdr_third and !is_disc && !is_float
        |=> tx_data == {cnt[6:0], 1'b0})
        else $error("word byte count wrong");
    chk_float_count: assert property (hdr_third and is_float
        |=> tx_data == {n_items[5:0], 2'b00})
        else $error("float byte count wrong");
    chk_fmt_exc: assert property (state == S_DECODE && accept && fmt_bad
        |=> exc && exc_code == EXC_DATA ##1 state == S_HDR)
        else $error("bad count not answered with code 03");
    chk_map_exc: assert property (state == S_CHK_RSP && last_item && item_bad
        |=> exc && exc_code == EXC_ADDR)
        else $error("unmapped address not answered with code 02");
    chk_stale_exc: assert property (state == S_CHK_RSP && last_item && !map_fail && stale
        |=> exc && exc_code == EXC_DEV)
        else $error("stale data not answered with code 04");
    chk_bit_place: assert property (state == S_FWAIT && is_disc
        |=> disc_bits[$past(idx[2:0])] == $past(mem_rsp.value[0]))
        else $error("discrete bit in wrong position");
    chk_pad_zero: assert property (state == S_FETCH && is_disc && idx[2:0] == 3'h0
        |-> disc_bits == 8'h00)
        else $error("unused discrete bits not cleared");
    chk_crc_tail: assert property (state == S_CRC && load && !crc_k
        |=> tx_data == $past(crc[7:0]))
        else $error("CRC low byte not sent first");
endmodule : mrb_read_builder

// *** test/mrb_master_model.sv ***
// Modbus master model: sends framed queries and drains replies
`timescale 1ns/1ps
module mrb_master_model (
    // Clock
    input  wire logic       sys_clk,
    // Query bytes
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_gap,
    // Reply bytes
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,
    // Drain speed
    input  wire logic       slow
);
    logic [7:0] got[$];

    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_gap   = 1'b0;
        tx_ready = 1'b1;
    end

    // Slow drain stalls every other cycle
    always @(negedge sys_clk) tx_ready <= slow ? ~tx_ready : 1'b1;
    always @(posedge sys_clk) if (tx_valid && tx_ready) got.push_back(tx_data);

    function automatic logic [15:0] crc16(input logic [7:0] f[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (f[i]) begin
            c = c ^ {8'h00, f[i]};
            for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        end
        return c;
    endfunction : crc16

    // Counts above eight floats are sent only where a refusal is wanted
    task automatic send(input logic [7:0] sa, fn, input logic [15:0] st, input logic [7:0] cnt);
        logic [7:0]  f[$];
        logic [15:0] c;
        f = '{sa, fn, st[15:8], st[7:0], 8'h00, cnt};
        c = crc16(f);
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        foreach (f[i]) begin
            @(negedge sys_clk);
            rx_valid <= 1'b1;
            rx_data  <= f[i];
        end
        @(negedge sys_clk);
        rx_valid <= 1'b0;
        // Idle line must not look like the last byte
        rx_data  <= ~rx_data;
    endtask : send

    task automatic junk(input int n);
        repeat (n) begin
            @(negedge sys_clk);
            rx_valid <= 1'b1;
            rx_data  <= rx_data + 8'h35;
        end
        @(negedge sys_clk);
        rx_valid <= 1'b0;
        rx_gap   <= 1'b1;
        @(negedge sys_clk);
        rx_gap   <= 1'b0;
    endtask : junk
endmodule : mrb_master_model

// *** test/tb_top.sv ***
// Self-checking bench for the read response builder
`timescale 1ns/1ps
module tb_top;
    import mrb_pkg::*;
    localparam logic [7:0] SA = 8'h11;
    logic sys_clk, rst_n, rx_valid, rx_gap, float_mode, byte_reverse, pair_swap;
    logic image_update, refresh_req, tx_valid, tx_ready, slow, fresh;
    logic [7:0] rx_data, tx_data;
    logic [7:0] exp_q[$];
    mrb_mem_req_type mem_req;
    mrb_mem_rsp_type mem_rsp;
    mrb_kind_type    kind_seen;
    int mismatches, checks_done, refresh_cnt, cyc;

    mrb_read_builder uut (.sys_clk(sys_clk), .rst_n(rst_n), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_gap(rx_gap), .slave_addr(SA), .float_mode(float_mode),
        .byte_reverse(byte_reverse), .pair_swap(pair_swap), .mem_req(mem_req),
        .mem_rsp(mem_rsp), .image_update(image_update), .refresh_req(refresh_req),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    mrb_master_model m (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_gap(rx_gap), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .slow(slow));

    // --------------------------------------------------------------
    // Memory image: 0150 and 0200 upward unmapped, 0160 not level-1 readable
    // --------------------------------------------------------------
    function automatic logic [31:0] val_of(input logic [15:0] a);
        return {~a, a ^ (a >> 1)};
    endfunction : val_of
    always_comb begin
        mem_rsp.mapped    = (mem_req.addr < 16'h0200) && (mem_req.addr != 16'h0150);
        mem_rsp.read_lvl1 = (mem_req.addr != 16'h0160);
        mem_rsp.fresh     = fresh;
        mem_rsp.value     = val_of(mem_req.addr);
    end

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (refresh_req === 1'b1) refresh_cnt++;
    always @(posedge sys_clk) if (mem_req.valid === 1'b1) kind_seen <= mem_req.kind;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            test_done();
        end
    end

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic run(input logic [7:0] fn, input logic [15:0] st, input logic [7:0] n,
                       input logic upd);
        if (upd) begin
            @(negedge sys_clk) image_update <= 1'b1;
            @(negedge sys_clk) image_update <= 1'b0;
        end
        m.got.delete();
        m.send(SA, fn, st, n);
    endtask : run

    task automatic expect_reply;
        logic [15:0] c;
        int          w;
        c = m.crc16(exp_q);
        exp_q.push_back(c[7:0]);
        exp_q.push_back(c[15:8]);
        for (w = 0; w < 600 && m.got.size() < exp_q.size(); w++) @(posedge sys_clk);
        // End on a falling edge so that following input changes stay off the sampling edge
        repeat (30) @(negedge sys_clk);
        check("reply length", 16'(m.got.size()), 16'(exp_q.size()));
        foreach (exp_q[i]) begin
            if (i < m.got.size())
                check("reply byte", {8'h00, m.got[i]}, {8'h00, exp_q[i]});
        end
    endtask : expect_reply

    task automatic exc(input logic [7:0] fn, cd, input logic [15:0] st, input logic [7:0] n,
                       input logic upd);
        run(fn, st, n, upd);
        exp_q = '{SA, fn | EXC_FLAG, cd};
        expect_reply();
    endtask : exc

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_disc;
        int          r0;
        logic [31:0] v;
        for (int n = 8; n <= 10; n += 2) begin
            r0 = refresh_cnt;
            run(FN_DISC, 16'(n), 8'(n), 1'b1);
            exp_q = '{SA, FN_DISC, 8'((n + 7) / 8)};
            repeat ((n + 7) / 8) exp_q.push_back(8'h00);
            for (int k = 0; k < n; k++) begin
                v = val_of(16'(n + k));
                exp_q[3 + k / 8][k % 8] = v[0];
            end
            expect_reply();
            check("refresh pulses", 16'(refresh_cnt - r0), 16'h0001);
            check("lookup kind", 16'(kind_seen), 16'(KIND_BIT));
        end
    endtask : t_disc

    task automatic t_word;
        logic [31:0] v;
        float_mode = 1'b0;
        foreach (exp_q[i]) exp_q[i] = 8'h00;
        for (int f = 3; f <= 4; f++) begin
            slow = (f == 4);
            run(8'(f), 16'h0010, 8'd3, 1'b1);
            exp_q = '{SA, 8'(f), 8'h06};
            for (int i = 0; i < 3; i++) begin
                v = val_of(16'h0010 + 16'(i));
                exp_q.push_back(v[15:8]);
                exp_q.push_back(v[7:0]);
            end
            expect_reply();
            check("lookup kind", 16'(kind_seen), 16'(KIND_WORD));
        end
        slow = 1'b0;
    endtask : t_word

    task automatic t_float;
        logic [31:0] v;
        int          idx, n;
        float_mode = 1'b1;
        for (int o = 0; o < 4; o++) begin
            {byte_reverse, pair_swap} = 2'(o);
            n = (o == 3) ? 8 : 2;
            slow = (o == 1);
            run(FN_HOLD, 16'h0020, 8'(2 * n), 1'b1);
            exp_q = '{SA, FN_HOLD, 8'(4 * n)};
            for (int i = 0; i < n; i++) begin
                v = val_of(16'h0020 + 16'(2 * i));
                for (int j = 0; j < 4; j++) begin
                    idx = byte_reverse ? (pair_swap ? j ^ 2 : 3 - j) : (pair_swap ? j ^ 1 : j);
                    exp_q.push_back(v[8 * idx +: 8]);
                end
            end
            expect_reply();
            check("lookup kind", 16'(kind_seen), 16'(KIND_FLOAT));
        end
        slow = 1'b0;
    endtask : t_float

    task automatic t_exc;
        exc(FN_HOLD, EXC_DATA, 16'h0020, 8'd3, 1'b1);
        exc(FN_HOLD, EXC_DATA, 16'h0020, 8'd18, 1'b1);
        float_mode = 1'b0;
        exc(FN_INPUT, EXC_ADDR, 16'h014f, 8'd3, 1'b1);
        exc(FN_DISC, EXC_ADDR, 16'h015f, 8'd2, 1'b1);
        fresh = 1'b0;
        exc(FN_HOLD, EXC_DEV, 16'h0030, 8'd1, 1'b1);
        fresh = 1'b1;
        m.junk(3);
        run(FN_HOLD, 16'h0040, 8'd1, 1'b1);
        exp_q = '{SA, FN_HOLD, 8'h02, 8'h00, 8'h40 ^ 8'h20};
        expect_reply();
        exc(FN_HOLD, EXC_BUSY, 16'h0040, 8'd1, 1'b0);
        m.got.delete();
        m.send(8'h3c, FN_HOLD, 16'h0041, 8'd1);
        // Own station but an unserved code: must also stay silent
        m.send(SA, 8'h05, 16'h0041, 8'd1);
        repeat (200) @(posedge sys_clk);
        check("foreign station reply", 16'(m.got.size()), 16'h0000);
    endtask : t_exc

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    initial begin
        {rst_n, float_mode, byte_reverse, pair_swap, image_update, slow} = 6'h00;
        fresh = 1'b1;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk) rst_n = 1'b1;
        t_disc();
        t_word();
        t_float();
        t_exc();
        test_done();
    end
endmodule : tb_top
